// ### verilog/tcp_pkg.sv
// Constants for the timer compare / PWM / one-pulse channel.
// Assumes a 32-bit APB slave with 12-bit byte addresses and one aligned word per register.
package tcp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  // Register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_EVENT   = 12'h004;
  localparam logic [11:0] OFS_MODE    = 12'h008;
  localparam logic [11:0] OFS_OUTPUT  = 12'h00c;
  localparam logic [11:0] OFS_COUNT   = 12'h010;
  localparam logic [11:0] OFS_RELOAD  = 12'h014;
  localparam logic [11:0] OFS_COMPARE = 12'h018;
  localparam logic [11:0] OFS_FLAG    = 12'h01c;
  localparam logic [11:0] OFS_MASK    = 12'h020;

  // Control register fields
  localparam int unsigned BIT_CEN  = 0;
  localparam int unsigned BIT_DIR  = 1;
  localparam int unsigned POS_CMS  = 2;
  localparam int unsigned BIT_OPM  = 4;
  localparam int unsigned BIT_ARBE = 5;
  // Event register
  localparam int unsigned BIT_UG   = 0;
  // Mode register
  localparam int unsigned POS_OCM  = 0;
  localparam int unsigned BIT_OCBE = 3;
  // Output register
  localparam int unsigned BIT_CCE  = 0;
  localparam int unsigned BIT_CCP  = 1;
  // Flag and mask registers
  localparam int unsigned BIT_MATCH = 0;

  // Output compare mode codes
  localparam logic [2:0] OCM_FROZEN   = 3'h0;
  localparam logic [2:0] OCM_ACTIVE   = 3'h1;
  localparam logic [2:0] OCM_INACTIVE = 3'h2;
  localparam logic [2:0] OCM_TOGGLE   = 3'h3;
  localparam logic [2:0] OCM_FORCE_LO = 3'h4;
  localparam logic [2:0] OCM_FORCE_HI = 3'h5;
  localparam logic [2:0] OCM_PWM1     = 3'h6;
  localparam logic [2:0] OCM_PWM2     = 3'h7;

  // Center-align select codes
  localparam logic [1:0] CMS_EDGE = 2'h0;
  localparam logic [1:0] CMS_DOWN = 2'h1;
  localparam logic [1:0] CMS_UP   = 2'h2;
  localparam logic [1:0] CMS_BOTH = 2'h3;

  // Reset values
  localparam logic [15:0] RST_RELOAD  = 16'hffff;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [15:0] RST_COUNT   = 16'h0000;

endpackage

// ### verilog/tcp_timer_channel.sv
// Timer counter with one compare channel: compare actions, PWM modes 1/2,
// edge and center alignment, one-pulse stop, shadowed compare and reload values.
// Assumes an APB master on pclk; the counter ticks once per pclk while enabled.
`timescale 1ns/1ps

module tcp_timer_channel
  import tcp_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tcp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [tcp_pkg::DATA_W-1:0]  pwdata,
  output logic      [tcp_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             match_irq,
  output logic                             channel_output_pin,
  output logic                             channel_output_pin_oe
);

  import tcp_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] arr_buf;
    logic [15:0] arr_sh;
    logic [15:0] ccr_buf;
    logic [15:0] ccr_sh;
    logic        cen;
    logic        dir;
    logic [1:0]  cms;
    logic        single_pulse_mode;
    logic        arbe;
    logic [2:0]  ocm;
    logic        ocbe;
    logic        cce;
    logic        ccp;
    logic        flag;
    logic        mask;
    logic        irq;
    logic        ref_lvl;
    logic        pwm_prev;
    logic [2:0]  ocm_prev;
    logic        pin;
    logic        pin_oe;
    logic [31:0] rdata;
  } tcp_state_type;

  tcp_state_type st;
  tcp_state_type next_st;

  logic wr_access;
  logic rd_setup;
  logic ctrl_wr;
  logic mode_wr;
  logic cnt_wr;
  logic ug;
  logic uev_cnt;
  logic update_event;
  logic match;
  logic match_qual;
  logic pwm_lvl;

  function automatic logic reg_hit(input logic [11:0] a);
    case (a)
      OFS_CONTROL, OFS_EVENT, OFS_MODE, OFS_OUTPUT, OFS_COUNT,
      OFS_RELOAD, OFS_COMPARE, OFS_FLAG, OFS_MASK: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // PWM mode 1 level, inverted for mode 2; direction picks the comparison sense
  function automatic logic pwm_level(input logic down, input logic [15:0] c,
                                     input logic [15:0] cmp, input logic inv);
    logic lvl;
    lvl = down ? (c <= cmp) : (c < cmp);
    pwm_level = lvl ^ inv;
  endfunction

  function automatic logic flag_dir_ok(input logic [1:0] cms, input logic down);
    case (cms)
      CMS_EDGE: flag_dir_ok = 1'b1;
      CMS_DOWN: flag_dir_ok = down;
      CMS_UP:   flag_dir_ok = ~down;
      default:  flag_dir_ok = 1'b1;
    endcase
  endfunction

  // Zero wait states: every access phase completes in its first cycle
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~reg_hit(paddr);
  assign prdata    = st.rdata;
  assign match_irq = st.irq;
  assign channel_output_pin    = st.pin;
  assign channel_output_pin_oe = st.pin_oe;

  assign wr_access = psel & penable & pwrite & reg_hit(paddr);
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign ctrl_wr   = wr_access & (paddr == OFS_CONTROL);
  assign mode_wr   = wr_access & (paddr == OFS_MODE);
  assign cnt_wr    = wr_access & (paddr == OFS_COUNT);
  assign ug        = wr_access & (paddr == OFS_EVENT) & pwdata[BIT_UG];

  // Match comparison only while counting: a stopped counter would otherwise retoggle every cycle
  assign match      = st.cen & (st.cnt == st.ccr_sh);
  assign match_qual = match & flag_dir_ok(st.cms, st.dir);
  assign pwm_lvl    = pwm_level(st.dir, st.cnt, st.ccr_sh, st.ocm[0]);
  assign update_event        = uev_cnt | ug;

  always_comb begin
    next_st = st;
    uev_cnt = 1'b0;

    // Counter
    if (st.cen) begin
      if (st.cms == CMS_EDGE) begin
        if (!st.dir) begin
          if (st.cnt == st.arr_sh) begin
            next_st.cnt = 16'h0000;
            uev_cnt     = 1'b1;
          end else begin
            next_st.cnt = st.cnt + 16'h0001;
          end
        end else begin
          if (st.cnt == 16'h0000) begin
            next_st.cnt = st.arr_sh;
            uev_cnt     = 1'b1;
          end else begin
            next_st.cnt = st.cnt - 16'h0001;
          end
        end
      end else begin
        // Center mode turns at both ends; direction held from before the start
        if (!st.dir) begin
          if (st.cnt == st.arr_sh) begin
            next_st.cnt = st.cnt - 16'h0001;
            next_st.dir = 1'b1;
            uev_cnt     = 1'b1;
          end else begin
            next_st.cnt = st.cnt + 16'h0001;
          end
        end else begin
          if (st.cnt == 16'h0000) begin
            next_st.cnt = 16'h0001;
            next_st.dir = 1'b0;
            uev_cnt     = 1'b1;
          end else begin
            next_st.cnt = st.cnt - 16'h0001;
          end
        end
      end
    end

    if (uev_cnt && st.single_pulse_mode) begin
      next_st.cen = 1'b0;
    end

    // Forced update reinitialises the counter
    if (ug) begin
      next_st.cnt = (st.cms == CMS_EDGE && st.dir) ? st.arr_buf : 16'h0000;
    end

    // Reference signal; update events are not an input here
    case (st.ocm)
      OCM_FROZEN:   next_st.ref_lvl = st.ref_lvl;
      OCM_ACTIVE:   next_st.ref_lvl = match ? 1'b1 : st.ref_lvl;
      OCM_INACTIVE: next_st.ref_lvl = match ? 1'b0 : st.ref_lvl;
      OCM_TOGGLE:   next_st.ref_lvl = match ? ~st.ref_lvl : st.ref_lvl;
      OCM_FORCE_LO: next_st.ref_lvl = 1'b0;
      OCM_FORCE_HI: next_st.ref_lvl = 1'b1;
      OCM_PWM1, OCM_PWM2: begin
        if (pwm_lvl != st.pwm_prev || st.ocm_prev == OCM_FROZEN) begin
          next_st.ref_lvl = pwm_lvl;
        end
      end
      default: next_st.ref_lvl = st.ref_lvl;
    endcase
    next_st.pwm_prev = pwm_lvl;
    next_st.ocm_prev = st.ocm;

    next_st.pin    = st.cce & (st.ref_lvl ^ st.ccp);
    next_st.pin_oe = st.cce;

    // Register writes
    if (wr_access) begin
      case (paddr)
        OFS_CONTROL: begin
          next_st.cen  = pwdata[BIT_CEN];
          next_st.cms  = pwdata[POS_CMS +: 2];
          next_st.single_pulse_mode  = pwdata[BIT_OPM];
          next_st.arbe = pwdata[BIT_ARBE];
          // Hardware owns the direction in center mode
          if (st.cms == CMS_EDGE) begin
            next_st.dir = pwdata[BIT_DIR];
          end
        end
        OFS_MODE: begin
          next_st.ocm  = pwdata[POS_OCM +: 3];
          next_st.ocbe = pwdata[BIT_OCBE];
        end
        OFS_OUTPUT: begin
          next_st.cce = pwdata[BIT_CCE];
          next_st.ccp = pwdata[BIT_CCP];
        end
        OFS_COUNT: begin
          next_st.cnt = pwdata[15:0];
          if (st.cms != CMS_EDGE && st.cen) begin
            if (pwdata[15:0] == 16'h0000) begin
              next_st.dir = 1'b0;
            end else if (pwdata[15:0] == st.arr_sh) begin
              next_st.dir = 1'b1;
            end
          end
        end
        OFS_RELOAD:  next_st.arr_buf = pwdata[15:0];
        OFS_COMPARE: next_st.ccr_buf = pwdata[15:0];
        OFS_MASK:    next_st.mask    = pwdata[BIT_MATCH];
        default: ;
      endcase
    end

    // Shadows follow the buffers at once unless buffered
    if (update_event || !st.arbe) begin
      next_st.arr_sh = next_st.arr_buf;
    end
    if (update_event || !st.ocbe) begin
      next_st.ccr_sh = next_st.ccr_buf;
    end

    // Set beats a same-cycle write-one clear
    if (wr_access && paddr == OFS_FLAG && pwdata[BIT_MATCH]) begin
      next_st.flag = 1'b0;
    end
    if (match_qual) begin
      next_st.flag = 1'b1;
    end
    next_st.irq = next_st.flag & next_st.mask;

    // Read data is captured in the setup cycle and stands through the access
    if (rd_setup) begin
      next_st.rdata = 32'h0000_0000;
      case (paddr)
        OFS_CONTROL: begin
          next_st.rdata[BIT_CEN]      = st.cen;
          next_st.rdata[BIT_DIR]      = st.dir;
          next_st.rdata[POS_CMS +: 2] = st.cms;
          next_st.rdata[BIT_OPM]      = st.single_pulse_mode;
          next_st.rdata[BIT_ARBE]     = st.arbe;
        end
        OFS_MODE: begin
          next_st.rdata[POS_OCM +: 3] = st.ocm;
          next_st.rdata[BIT_OCBE]     = st.ocbe;
        end
        OFS_OUTPUT: begin
          next_st.rdata[BIT_CCE] = st.cce;
          next_st.rdata[BIT_CCP] = st.ccp;
        end
        OFS_COUNT:   next_st.rdata[15:0]      = st.cnt;
        OFS_RELOAD:  next_st.rdata[15:0]      = st.arr_buf;
        OFS_COMPARE: next_st.rdata[15:0]      = st.ccr_buf;
        OFS_FLAG:    next_st.rdata[BIT_MATCH] = st.flag;
        OFS_MASK:    next_st.rdata[BIT_MATCH] = st.mask;
        default:     next_st.rdata            = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= '0;
      st.cnt     <= RST_COUNT;
      st.arr_buf <= RST_RELOAD;
      st.arr_sh  <= RST_RELOAD;
      st.ccr_buf <= RST_COMPARE;
      st.ccr_sh  <= RST_COMPARE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_set_a: assert property (match_qual |=> st.flag)
    else $error("match flag not set after qualified match");

  irq_gate_a: assert property ((match_qual && st.mask && !(wr_access && paddr == OFS_MASK)) |=> match_irq)
    else $error("unmasked match gave no interrupt");

  toggle_a: assert property ((st.ocm == OCM_TOGGLE && match && !mode_wr) |=> st.ref_lvl != $past(st.ref_lvl))
    else $error("toggle mode did not invert reference");

  // Pin lags the reference by one edge, so enable and polarity are those of the cycle before
  force_high_a: assert property ((st.ocm == OCM_FORCE_HI && !mode_wr)
                                 |=> st.ref_lvl ##1 channel_output_pin == $past(st.cce && !st.ccp))
    else $error("forced high reference not seen at pin");

  force_low_a: assert property ((st.ocm == OCM_FORCE_LO) |=> !st.ref_lvl)
    else $error("forced low reference not low");

  active_set_a: assert property ((st.ocm == OCM_ACTIVE && match) |=> st.ref_lvl)
    else $error("set active mode did not raise reference on match");

  inactive_clear_a: assert property ((st.ocm == OCM_INACTIVE && match) |=> !st.ref_lvl)
    else $error("set inactive mode did not lower reference on match");

  // Update events reach the shadows and the counter, not the reference; a frozen reference must ignore them
  frozen_hold_a: assert property ((st.ocm == OCM_FROZEN) |=> $stable(st.ref_lvl))
    else $error("frozen mode changed the reference");

  // A restart written by software in the cycle after the stop is legal
  opm_stop_a: assert property ((st.single_pulse_mode && uev_cnt && !ctrl_wr) |=> !st.cen ##1 (!st.cen || $past(ctrl_wr)))
    else $error("single pulse did not stop counter");

  direct_load_a: assert property (!st.ocbe |=> st.ccr_sh == st.ccr_buf)
    else $error("unbuffered compare value not used at once");

  irq_masked_a: assert property ((!st.mask && !(wr_access && paddr == OFS_MASK)) |=> !match_irq)
    else $error("masked match raised an interrupt");

  flag_sticky_a: assert property ((st.flag && !(wr_access && paddr == OFS_FLAG)) |=> st.flag)
    else $error("match flag dropped without a clear");

  shadow_hold_a: assert property ((st.ocbe && !update_event) |=> st.ccr_sh == $past(st.ccr_sh))
    else $error("buffered compare shadow changed without update");

  pin_level_a: assert property (st.cce |=> channel_output_pin_oe && channel_output_pin == $past(st.ref_lvl ^ st.ccp))
    else $error("pin level does not follow reference and polarity");

  pin_off_a: assert property (!st.cce |=> !channel_output_pin_oe && !channel_output_pin)
    else $error("pin driven while output disabled");

  center_flag_a: assert property ((st.cms == CMS_DOWN && !st.dir && !st.flag) |=> !st.flag)
    else $error("center select 01 flagged while counting up");

  edge_up_a: assert property ((st.cen && st.cms == CMS_EDGE && !st.dir && st.cnt != st.arr_sh && !wr_access)
                              |=> st.cnt == 16'($past(st.cnt) + 16'h0001))
    else $error("edge up counter did not advance by one");

  pwm_cover_c: cover property (st.ocm == OCM_PWM1 && st.cen && $rose(st.ref_lvl));
  opm_cover_c: cover property (st.single_pulse_mode && $fell(st.cen));
  center_cover_c: cover property (st.cms != CMS_EDGE && $rose(st.dir));
  irq_cover_c: cover property ($rose(match_irq));
  center_flag_c: cover property (st.cms == CMS_DOWN && st.dir && match_qual);

endmodule

// ### verification/tcp_gpio_pad.sv
// Behavioural GPIO pad that the channel output drives.
// Assumes an external pull-up on the pad and nothing else driving it.
`timescale 1ns/1ps
module tcp_gpio_pad (
  input  wire logic pin,
  input  wire logic oe,
  output logic      pad
);
  // A released pad goes to the pull-up level instead of keeping the last driven value
  assign pad = oe ? pin : 1'b1;
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the timer compare channel with a GPIO pad model.
// Assumes a zero-wait APB slave and one counter tick per pclk while enabled.
`timescale 1ns/1ps
module tb_top;
  import tcp_pkg::*;
  localparam logic [11:0] RD_OFS [10] = '{OFS_CONTROL, OFS_EVENT, OFS_MODE, OFS_OUTPUT, OFS_COUNT,
                                          OFS_RELOAD, OFS_COMPARE, OFS_FLAG, OFS_MASK, 12'h024};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        match_irq;
  logic        pin;
  logic        oe;
  logic        pad;
  logic [32:0] rd_q[$];
  logic [32:0] rd_exp;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #4 pclk = ~pclk;

  tcp_timer_channel tcp_timer_channel_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_irq(match_irq), .channel_output_pin(pin), .channel_output_pin_oe(oe)
  );
  tcp_gpio_pad tcp_gpio_pad_inst (.pin(pin), .oe(oe), .pad(pad));

  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Summary: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Sized for the whole run with a wide margin
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Read results come off the queue in issue order
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      rd_exp = rd_q.pop_front();
      check($sformatf("read_%h", paddr), {pslverr, prdata}, rd_exp);
    end
  end

  // One idle edge first so a release and the next setup never share a time step
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask

  task automatic apb_rd(input logic [11:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb_xfer(1'b0, a, 32'h0);
  endtask

  // Preset the reference, arm one pulse, then judge the single match
  task automatic oc_run(input logic [2:0] m);
    logic [15:0] rl;
    logic [15:0] cp;
    logic        pol, en, msk, b, p, hit, ref_lvl;
    rl = 16'(8 + $urandom_range(24));
    cp = 16'(1 + $urandom_range(rl - 2));
    {pol, en, msk, b, p} = 5'($urandom);
    hit = !b;
    case (m)
      OCM_ACTIVE:   ref_lvl = hit | p;
      OCM_INACTIVE: ref_lvl = !hit & p;
      OCM_TOGGLE:   ref_lvl = hit ^ p;
      OCM_FORCE_LO: ref_lvl = 1'b0;
      OCM_FORCE_HI: ref_lvl = 1'b1;
      default:      ref_lvl = p;
    endcase
    apb_wr(OFS_CONTROL, 32'h0);
    apb_wr(OFS_OUTPUT, {30'h0, pol, en});
    apb_wr(OFS_MASK, {31'h0, msk});
    apb_wr(OFS_MODE, {28'h0, b, p ? OCM_FORCE_HI : OCM_FORCE_LO});
    apb_wr(OFS_RELOAD, {16'h0, rl});
    apb_wr(OFS_COMPARE, 32'hffff);
    apb_wr(OFS_EVENT, 32'h1);
    apb_wr(OFS_COMPARE, {16'h0, cp});
    apb_wr(OFS_FLAG, 32'h1);
    apb_wr(OFS_MODE, {28'h0, b, m});
    apb_wr(OFS_CONTROL, 32'h11);
    repeat (rl + 8) @(posedge pclk);
    check("pad_level", {32'h0, pad}, {32'h0, en ? ref_lvl ^ pol : 1'b1});
    check("pin_oe", {32'h0, oe}, {32'h0, en});
    apb_rd(OFS_FLAG, {32'h0, hit});
    check("match_irq", {32'h0, match_irq}, {32'h0, hit & msk});
    apb_wr(OFS_FLAG, 32'h1);
    apb_rd(OFS_FLAG, 33'h0);
    apb_rd(OFS_CONTROL, 33'h10);
    apb_rd(OFS_COUNT, 33'h0);
  endtask

  // Count high samples of the pad over one period, or over the whole single pulse
  task automatic pwm_run(input logic [2:0] m, input logic dir, input logic single_pulse_mode, input logic [15:0] rl,
                         input logic [15:0] cp, input int exp_hi);
    int hi;
    hi = 0;
    apb_wr(OFS_CONTROL, {26'h0, 1'b1, single_pulse_mode, 2'b00, dir, 1'b0});
    apb_wr(OFS_MODE, 32'h8);
    apb_wr(OFS_OUTPUT, 32'h1);
    apb_wr(OFS_RELOAD, {16'h0, rl});
    apb_wr(OFS_COMPARE, {16'h0, cp});
    apb_wr(OFS_EVENT, 32'h1);
    apb_wr(OFS_MODE, {28'h1, m});
    apb_wr(OFS_CONTROL, {26'h0, 1'b1, single_pulse_mode, 2'b00, dir, 1'b1});
    if (!single_pulse_mode) repeat (rl + 4) @(posedge pclk);
    repeat (single_pulse_mode ? rl + 12 : rl + 1) begin
      @(posedge pclk);
      hi += pad;
    end
    check("pwm_high", 33'(hi), 33'(exp_hi));
  endtask

  // Stop once while counting up and once while counting down, past compare each time
  task automatic center_run(input logic [1:0] c);
    apb_wr(OFS_MODE, 32'h0);
    apb_wr(OFS_RELOAD, 32'd60);
    apb_wr(OFS_COMPARE, 32'd20);
    apb_wr(OFS_EVENT, 32'h1);
    apb_wr(OFS_FLAG, 32'h1);
    apb_wr(OFS_CONTROL, {28'h0, c, 2'b00});
    apb_wr(OFS_CONTROL, {28'h0, c, 2'b01});
    repeat (30) @(posedge pclk);
    apb_wr(OFS_CONTROL, {28'h0, c, 2'b00});
    apb_rd(OFS_FLAG, {32'h0, c != CMS_DOWN});
    apb_wr(OFS_FLAG, 32'h1);
    apb_wr(OFS_CONTROL, {28'h0, c, 2'b01});
    repeat (74) @(posedge pclk);
    apb_wr(OFS_CONTROL, {28'h0, c, 2'b10});
    apb_rd(OFS_FLAG, {32'h0, c != CMS_UP});
    apb_wr(OFS_CONTROL, 32'h2);
    apb_rd(OFS_CONTROL, 33'h2);
    apb_wr(OFS_CONTROL, 32'h0);
  endtask

  initial begin
    logic [15:0] rl;
    logic [15:0] cps[3];
    void'($urandom(32'h54f2));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check("oe_reset", {32'h0, oe}, 33'h0);
    foreach (RD_OFS[i]) begin
      apb_rd(RD_OFS[i], RD_OFS[i] == OFS_RELOAD ? {17'h0, RST_RELOAD} : {RD_OFS[i] == 12'h024, 32'h0});
    end
    $display("test reset_values done");
    for (int i = 0; i < 18; i++) begin
      oc_run(3'(i % 6));
    end
    $display("test compare_actions done");
    rl = 16'(6 + $urandom_range(20));
    cps = '{16'h0, 16'(1 + $urandom_range(rl - 2)), rl + 16'h1};
    foreach (cps[i]) begin
      pwm_run(OCM_PWM1, 1'b0, 1'b0, rl, cps[i], cps[i] > rl ? rl + 1 : cps[i]);
      pwm_run(OCM_PWM1, 1'b1, 1'b0, rl, cps[i], cps[i] > rl ? rl + 1 : cps[i] + 1);
    end
    pwm_run(OCM_PWM2, 1'b0, 1'b0, rl, cps[1], rl + 1 - cps[1]);
    pwm_run(OCM_PWM2, 1'b0, 1'b1, rl, cps[1], rl + 1 - cps[1]);
    check("pulse_end", {32'h0, pad}, 33'h0);
    apb_rd(OFS_CONTROL, 33'h30);
    $display("test pwm_modes done");
    center_run(CMS_DOWN);
    center_run(CMS_UP);
    center_run(CMS_BOTH);
    $display("test center_flags done");
    print_verdict();
  end
endmodule
